//--- shared/itcc_params.svh
`ifndef ITCC_PARAMS_SVH
`define ITCC_PARAMS_SVH
// ==========================================
// Register map, index = channel * 2 + reg
`define ITCC_OFS_CLK_CTRL  1'b0
`define ITCC_OFS_IO_CTRL   1'b1
`define ITCC_OFS_COUNTER   4'hA
`define ITCC_OFS_GEN_A     4'hB
`define ITCC_OFS_GEN_B     4'hC
`define ITCC_OFS_CH_SEL    4'hD
`define ITCC_OFS_MODE      4'hE
// ==========================================
// Reset values
`define ITCC_RST_CLK_CTRL  8'h80
`define ITCC_RST_IO_CTRL   8'h88
`define ITCC_RST_GEN       16'hFFFF
// ==========================================
// Field positions
`define ITCC_CLR_HI        6
`define ITCC_CLR_LO        5
`define ITCC_EDGE_HI       4
`define ITCC_EDGE_LO       3
`define ITCC_PSC_HI        2
`define ITCC_IOB_HI        6
`define ITCC_IOB_LO        4
`define ITCC_IOA_HI        2
`define ITCC_IOA_LO        0
`define ITCC_RSV_MASK_CLK  8'h80
`define ITCC_RSV_MASK_IO   8'h88
`define ITCC_PHASE_CH      2
`endif

//--- shared/itcc_pkg.sv
package itcc_pkg;
  typedef enum logic [1:0] {
    ITCC_CLR_NONE,
    ITCC_CLR_GEN_A,
    ITCC_CLR_GEN_B,
    ITCC_CLR_SYNC
  } itcc_clr_t;
  typedef enum logic [1:0] {
    ITCC_PIN_KEEP,
    ITCC_PIN_LOW,
    ITCC_PIN_HIGH,
    ITCC_PIN_TOGGLE
  } itcc_pin_act_t;
endpackage

//--- hdl/itcc_timer.sv
// Behaviour
// - Clock/clear control loads 0x80 at reset and standby entry.
// - Bits 6:5 pick clear: none, register A, register B, synchronous.
// - Register-tied clear follows compare match or capture per register mode.
// - Synchronous clear happens together with other synchronised channels.
// - Bits 4:3 pick external edge: rising, falling, or both when bit 4 set.
// - Channel 2 phase counting ignores its edge field.
// - Prescale codes 0..3 select system clock divided by 1, 2, 4, 8.
// - Prescale codes 4..7 select external clock pins A..D.
// - Internal source counts divided-clock falling edges; external uses edge field.
// - Channel 2 phase counting ignores its prescale field.
// - All five channels' clock/clear control registers behave alike, except channel 2 phase.
// - I/O control loads 0x88 at reset and standby entry.
// - Bit 7 of both registers and I/O bit 3 read as one.
// - Bits 6:4 codes 0..3: register B compare, pin none/0/1/toggle.
// - Register B codes 4, 5, 6/7 capture rising, falling, both edges.
// - Bits 2:0 set register A with the same encodings.
// - Compare pins stay 0 after reset until first match.
// - Channel 2 toggle code drives 1 at match instead.
// - Complementary or reset-sync PWM ignores channels 3 and 4 I/O control.
// - Capture copies counter to general register and sets its flag.
// - A selected clear event zeroes the counter.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`include "itcc_params.svh"
module itcc_timer
  import itcc_pkg::*;
#(
  parameter int NCH = 5
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              standby,
  // Register port
  input  wire logic [3:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [15:0]       rdata,
  // External clocks
  input  wire logic [3:0]        ext_clock_pin,
  // Capture/compare pins
  input  wire logic [NCH-1:0]    cc_pin_a_in,
  input  wire logic [NCH-1:0]    cc_pin_b_in,
  output logic      [NCH-1:0]    cc_pin_a_out,
  output logic      [NCH-1:0]    cc_pin_a_oe,
  output logic      [NCH-1:0]    cc_pin_b_out,
  output logic      [NCH-1:0]    cc_pin_b_oe,
  // Event flags
  output logic      [NCH-1:0]    flag_a,
  output logic      [NCH-1:0]    flag_b
);

  // ==========================================
  // Helpers
  function automatic logic edge_hit(input logic [2:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = sel[2] ? (rise | fall) : (sel[0] ? fall : rise);
  endfunction

  function automatic logic [7:0] field_sel(input logic [2:0] ch, input logic io);
    field_sel = 8'h00;
  endfunction

  logic [7:0]     clk_ctrl_q [NCH];
  logic [7:0]     io_ctrl_q  [NCH];
  logic [15:0]    cnt_q      [NCH];
  logic [15:0]    gen_a_q    [NCH];
  logic [15:0]    gen_b_q    [NCH];
  logic [NCH-1:0] sync_sel_q;
  logic           phase_q;
  logic           pwm_q;
  logic [2:0]     div_q;
  logic [2:0]     div_prev_q;
  logic [3:0]     ext_s1_q;
  logic [3:0]     ext_s2_q;
  logic [3:0]     ext_s3_q;
  logic [NCH-1:0] ca_s1_q, ca_s2_q, ca_s3_q;
  logic [NCH-1:0] cb_s1_q, cb_s2_q, cb_s3_q;
  logic           standby_q;

  logic [NCH-1:0] tick;
  logic [NCH-1:0] ev_a;
  logic [NCH-1:0] ev_b;
  logic [NCH-1:0] cap_a;
  logic [NCH-1:0] cap_b;
  logic [NCH-1:0] own_clr;
  logic           sync_clr;
  logic [NCH-1:0] io_on;

  wire logic       std_entry = standby & ~standby_q;
  wire logic [2:0] ch_idx    = addr[3:1];
  wire logic       ch_ok     = (addr < `ITCC_OFS_COUNTER);

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 4'h0;
      ext_s2_q <= 4'h0;
      ext_s3_q <= 4'h0;
      ca_s1_q  <= '0;
      ca_s2_q  <= '0;
      ca_s3_q  <= '0;
      cb_s1_q  <= '0;
      cb_s2_q  <= '0;
      cb_s3_q  <= '0;
    end else if (clk_en) begin
      ext_s1_q <= ext_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ca_s1_q  <= cc_pin_a_in;
      ca_s2_q  <= ca_s1_q;
      ca_s3_q  <= ca_s2_q;
      cb_s1_q  <= cc_pin_b_in;
      cb_s2_q  <= cb_s1_q;
      cb_s3_q  <= cb_s2_q;
    end
  end

  // ==========================================
  // Prescaler
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q      <= 3'h0;
      div_prev_q <= 3'h0;
      standby_q  <= 1'b0;
    end else if (clk_en) begin
      div_q      <= div_q + 3'h1;
      div_prev_q <= div_q;
      standby_q  <= standby;
    end
  end

  // ==========================================
  // Per-channel count and event logic
  always_comb begin
    sync_clr = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      logic [2:0] psc;
      logic [1:0] edg;
      logic [2:0] ioa;
      logic [2:0] iob;
      logic [3:0] rise;
      logic [3:0] fall;
      psc  = clk_ctrl_q[c][`ITCC_PSC_HI:0];
      edg  = clk_ctrl_q[c][`ITCC_EDGE_HI:`ITCC_EDGE_LO];
      ioa  = io_ctrl_q[c][`ITCC_IOA_HI:`ITCC_IOA_LO];
      iob  = io_ctrl_q[c][`ITCC_IOB_HI:`ITCC_IOB_LO];
      rise = ext_s2_q & ~ext_s3_q;
      fall = ~ext_s2_q & ext_s3_q;
      io_on[c] = !(pwm_q && c >= 3);
      if (c == `ITCC_PHASE_CH && phase_q) begin
        tick[c] = 1'b0;
      end else if (!psc[2]) begin
        case (psc[1:0])
          2'd0:    tick[c] = 1'b1;
          2'd1:    tick[c] = div_prev_q[0] & ~div_q[0];
          2'd2:    tick[c] = div_prev_q[1] & ~div_q[1];
          default: tick[c] = div_prev_q[2] & ~div_q[2];
        endcase
      end else begin
        tick[c] = edge_hit({edg[1], 1'b0, edg[0]}, rise[psc[1:0]],
                           fall[psc[1:0]]);
      end
      cap_a[c] = io_on[c] & ioa[2] &
                 edge_hit({ioa[1], 1'b0, ioa[0]}, ca_s2_q[c] & ~ca_s3_q[c],
                          ~ca_s2_q[c] & ca_s3_q[c]);
      cap_b[c] = io_on[c] & iob[2] &
                 edge_hit({iob[1], 1'b0, iob[0]}, cb_s2_q[c] & ~cb_s3_q[c],
                          ~cb_s2_q[c] & cb_s3_q[c]);
      ev_a[c] = ioa[2] ? cap_a[c] : (tick[c] && cnt_q[c] == gen_a_q[c]);
      ev_b[c] = iob[2] ? cap_b[c] : (tick[c] && cnt_q[c] == gen_b_q[c]);
      case (itcc_clr_t'(clk_ctrl_q[c][`ITCC_CLR_HI:`ITCC_CLR_LO]))
        ITCC_CLR_GEN_A: own_clr[c] = ev_a[c];
        ITCC_CLR_GEN_B: own_clr[c] = ev_b[c];
        default:        own_clr[c] = 1'b0;
      endcase
      if (sync_sel_q[c])
        sync_clr = sync_clr | own_clr[c];
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        clk_ctrl_q[c] <= `ITCC_RST_CLK_CTRL;
        io_ctrl_q[c]  <= `ITCC_RST_IO_CTRL;
      end
      sync_sel_q <= '0;
      phase_q    <= 1'b0;
      pwm_q      <= 1'b0;
    end else if (clk_en) begin
      if (std_entry) begin
        for (int c = 0; c < NCH; c++) begin
          clk_ctrl_q[c] <= `ITCC_RST_CLK_CTRL;
          io_ctrl_q[c]  <= `ITCC_RST_IO_CTRL;
        end
      end else if (wr && ch_ok) begin
        if (addr[0] == `ITCC_OFS_IO_CTRL)
          io_ctrl_q[ch_idx] <= wdata[7:0] | `ITCC_RSV_MASK_IO;
        else
          clk_ctrl_q[ch_idx] <= wdata[7:0] | `ITCC_RSV_MASK_CLK;
      end else if (wr && addr == `ITCC_OFS_CH_SEL) begin
        sync_sel_q <= wdata[NCH-1:0];
      end else if (wr && addr == `ITCC_OFS_MODE) begin
        phase_q <= wdata[0];
        pwm_q   <= wdata[1];
      end
    end
  end

  // ==========================================
  // Counters, general registers, flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c]   <= 16'h0000;
        gen_a_q[c] <= `ITCC_RST_GEN;
        gen_b_q[c] <= `ITCC_RST_GEN;
      end
      flag_a <= '0;
      flag_b <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        logic clr;
        clr = own_clr[c];
        if (clk_ctrl_q[c][`ITCC_CLR_HI:`ITCC_CLR_LO] == 2'b11)
          clr = sync_sel_q[c] & sync_clr;
        if (clr)
          cnt_q[c] <= 16'h0000;
        else if (tick[c])
          cnt_q[c] <= cnt_q[c] + 16'h0001;
        if (cap_a[c])
          gen_a_q[c] <= cnt_q[c];
        if (cap_b[c])
          gen_b_q[c] <= cnt_q[c];
        if (ev_a[c])
          flag_a[c] <= 1'b1;
        else if (wr && addr == 4'(2 * c) && !wdata[8])
          flag_a[c] <= 1'b0;
        if (ev_b[c])
          flag_b[c] <= 1'b1;
        else if (wr && addr == 4'(2 * c) && !wdata[9])
          flag_b[c] <= 1'b0;
      end
      if (wr && addr == `ITCC_OFS_COUNTER)
        cnt_q[0] <= wdata;
      if (wr && addr == `ITCC_OFS_GEN_A)
        gen_a_q[0] <= wdata;
      if (wr && addr == `ITCC_OFS_GEN_B)
        gen_b_q[0] <= wdata;
    end
  end

  // ==========================================
  // Compare pin outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_pin_a_out <= '0;
      cc_pin_b_out <= '0;
      cc_pin_a_oe  <= '0;
      cc_pin_b_oe  <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        logic [2:0] ioa;
        logic [2:0] iob;
        ioa = io_ctrl_q[c][`ITCC_IOA_HI:`ITCC_IOA_LO];
        iob = io_ctrl_q[c][`ITCC_IOB_HI:`ITCC_IOB_LO];
        cc_pin_a_oe[c] <= io_on[c] && !ioa[2] && ioa[1:0] != 2'b00;
        cc_pin_b_oe[c] <= io_on[c] && !iob[2] && iob[1:0] != 2'b00;
        if (io_on[c] && !ioa[2] && ev_a[c]) begin
          case (itcc_pin_act_t'(ioa[1:0]))
            ITCC_PIN_LOW:    cc_pin_a_out[c] <= 1'b0;
            ITCC_PIN_HIGH:   cc_pin_a_out[c] <= 1'b1;
            ITCC_PIN_TOGGLE: cc_pin_a_out[c] <= (c == 2) | ~cc_pin_a_out[c];
            default:         cc_pin_a_out[c] <= cc_pin_a_out[c];
          endcase
        end
        if (io_on[c] && !iob[2] && ev_b[c]) begin
          case (itcc_pin_act_t'(iob[1:0]))
            ITCC_PIN_LOW:    cc_pin_b_out[c] <= 1'b0;
            ITCC_PIN_HIGH:   cc_pin_b_out[c] <= 1'b1;
            ITCC_PIN_TOGGLE: cc_pin_b_out[c] <= (c == 2) | ~cc_pin_b_out[c];
            default:         cc_pin_b_out[c] <= cc_pin_b_out[c];
          endcase
        end
      end
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (clk_en && rd) begin
      if (ch_ok && addr[0] == `ITCC_OFS_IO_CTRL)
        rdata <= {8'h00, io_ctrl_q[ch_idx]};
      else if (ch_ok)
        rdata <= {6'h00, flag_b[ch_idx], flag_a[ch_idx], clk_ctrl_q[ch_idx]};
      else if (addr == `ITCC_OFS_COUNTER)
        rdata <= cnt_q[0];
      else if (addr == `ITCC_OFS_GEN_A)
        rdata <= gen_a_q[0];
      else if (addr == `ITCC_OFS_GEN_B)
        rdata <= gen_b_q[0];
      else if (addr == `ITCC_OFS_CH_SEL)
        rdata <= 16'(sync_sel_q);
      else if (addr == `ITCC_OFS_MODE)
        rdata <= {14'h0000, pwm_q, phase_q};
      else
        rdata <= 16'h0000;
    end
  end

endmodule

//--- verification/itcc_timer_asserts.sv
module itcc_timer_asserts #(
  parameter int NCH = 5
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rst_b,
  // Register port
  input wire logic           clk_en,
  input wire logic           standby,
  input wire logic [3:0]     addr,
  input wire logic [15:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [15:0]    rdata,
  // Pins and flags
  input wire logic [NCH-1:0] cc_pin_a_in,
  input wire logic [NCH-1:0] cc_pin_b_in,
  input wire logic [NCH-1:0] cc_pin_a_out,
  input wire logic [NCH-1:0] cc_pin_b_out,
  input wire logic [NCH-1:0] flag_a,
  input wire logic [NCH-1:0] flag_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       wr_seen_q;
  logic [7:0] io0_q;
  // ==========
  // Shadow of channel 0 io control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_seen_q <= 1'b0;
    end else if (wr || standby) begin
      wr_seen_q <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io0_q <= 8'h88;
    end else if (standby) begin
      io0_q <= 8'h88;
    end else if (wr && clk_en && addr == 4'h1) begin
      io0_q <= wdata[7:0];
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_clk_rst; rd && clk_en && addr == 4'h0 && !wr_seen_q |=> rdata[7:0] == 8'h80; endproperty
  property p_io_rst; rd && clk_en && addr == 4'h1 && !wr_seen_q |=> rdata[7:0] == 8'h88; endproperty
  property p_rsv7; rd && clk_en && addr < 4'hA |=> rdata[7]; endproperty
  property p_rsv3; rd && clk_en && addr < 4'hA && addr[0] |=> rdata[3]; endproperty
  property p_pin_low; !wr_seen_q |-> cc_pin_a_out == '0 && cc_pin_b_out == '0; endproperty
  property p_cap_b_rise; clk_en && io0_q[6:4] == 3'b100 && $rose(cc_pin_b_in[0]) |-> ##[1:5] flag_b[0]; endproperty
  property p_cap_b_fall; clk_en && io0_q[6:4] == 3'b101 && $fell(cc_pin_b_in[0]) |-> ##[1:5] flag_b[0]; endproperty
  property p_cap_a_both; clk_en && io0_q[2:0] == 3'b110 && $changed(cc_pin_a_in[0]) |-> ##[1:5] flag_a[0]; endproperty
  property p_sync_lag;
    io0_q[2] && $rose(cc_pin_a_in[0]) && !$past(cc_pin_a_in[0], 2) && !$past(cc_pin_a_in[0], 3)
      && !flag_a[0] |=> !flag_a[0];
  endproperty
  a_clk_rst: assert property (p_clk_rst) else $error("clock control reset value wrong");
  a_io_rst: assert property (p_io_rst) else $error("io control reset value wrong");
  a_rsv7: assert property (p_rsv7) else $error("bit 7 reads zero");
  a_rsv3: assert property (p_rsv3) else $error("io bit 3 reads zero");
  a_pin_low: assert property (p_pin_low) else $error("compare pin high before match");
  a_cap_b_rise: assert property (p_cap_b_rise) else $error("rising capture missed");
  a_cap_b_fall: assert property (p_cap_b_fall) else $error("falling capture missed");
  a_cap_a_both: assert property (p_cap_a_both) else $error("both-edge capture missed");
  a_sync_lag: assert property (p_sync_lag) else $error("capture skipped the synchroniser");
  c_capture: cover property (flag_b[0]);
  c_pin_high: cover property (cc_pin_a_out[0]);
  c_wr_rd: cover property (wr ##2 rd);
endmodule

bind itcc_timer itcc_timer_asserts #(.NCH(NCH)) u_chk (
  .clk, .rst_b, .clk_en, .standby, .addr, .wdata, .wr, .rd, .rdata, .cc_pin_a_in,
  .cc_pin_b_in, .cc_pin_a_out, .cc_pin_b_out, .flag_a, .flag_b
);

//--- verification/itcc_pins_model.sv
module itcc_pins_model #(
  parameter int NCH = 5
) (
  // Clock
  input  wire logic           clk,
  // Pins toward the timer
  output logic      [3:0]     ext_clock_pin,
  output logic      [NCH-1:0] cc_pin_a_in,
  output logic      [NCH-1:0] cc_pin_b_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ext_clock_pin = '0;
    cc_pin_a_in = '0;
    cc_pin_b_in = '0;
  end
  // Slow swings so the synchroniser sees every level
  task automatic ext_pulses(input int k, input int n);
    repeat (n) begin
      ext_clock_pin[k] <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clock_pin[k] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic drive(input int s, input logic v);
    if (s == 0)
      cc_pin_a_in[0] <= v;
    else
      cc_pin_b_in[0] <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- verification/itcc_timer_tb.sv
module itcc_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic        standby = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] v;
  logic [3:0]  ext_clock_pin;
  logic [4:0]  cc_pin_a_in, cc_pin_b_in, cc_pin_a_out, cc_pin_a_oe;
  logic [4:0]  cc_pin_b_out, cc_pin_b_oe, flag_a, flag_b;
  int          bad_count = 0;
  int          checked = 0;
  always #2.5 clk = ~clk;
  itcc_timer #(.NCH(5)) uut (
    .clk, .rst_b, .clk_en, .standby, .addr, .wdata, .wr, .rd, .rdata, .ext_clock_pin,
    .cc_pin_a_in, .cc_pin_b_in, .cc_pin_a_out, .cc_pin_a_oe, .cc_pin_b_out, .cc_pin_b_oe,
    .flag_a, .flag_b
  );
  itcc_pins_model #(.NCH(5)) pins (.clk, .ext_clock_pin, .cc_pin_a_in, .cc_pin_b_in);
  // ==========
  // Tasks
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic wait_pin(input int s, input logic e);
    int n = 0;
    while ((s ? cc_pin_b_out[0] : cc_pin_a_out[0]) !== e && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("cmp_pin", {15'h0, s ? cc_pin_b_out[0] : cc_pin_a_out[0]}, {15'h0, e});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  // ==========
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 10; c++) begin
      rreg(c[3:0]);
      chk("rst", {8'h00, v[7:0]}, c[0] ? 16'h0088 : 16'h0080);
      wreg(c[3:0], 16'h0000);
      rreg(c[3:0]);
      chk("rsv", {8'h00, v[7:0]}, c[0] ? 16'h0088 : 16'h0080);
      wreg(c[3:0], 16'h007F);
      rreg(c[3:0]);
      chk("rw", {8'h00, v[7:0]}, 16'h00FF);
    end
    $display("test regs done");
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    standby <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 10; c++) begin
      rreg(c[3:0]);
      chk("stby", {8'h00, v[7:0]}, c[0] ? 16'h0088 : 16'h0080);
    end
    rreg(4'hF);
    chk("unmapped", v, 16'h0000);
    $display("test standby done");
    for (int s = 0; s < 2; s++) begin
      wreg(4'h0, s ? 16'h0040 : 16'h0020);
      wreg(4'hB + s[3:0], 16'h0040);
      wreg(4'hA, 16'h0000);
      for (int k = 0; k < 4; k++) begin
        wreg(4'h1, 16'(k == 0 ? 2 : k == 1 ? 1 : 3) << (4 * s));
        wait_pin(s, !k[0]);
        chk("cmp_oe", {15'h0, s ? cc_pin_b_oe[0] : cc_pin_a_oe[0]}, 16'h0001);
      end
      wreg(4'h1, 16'h0000);
      repeat (150) @(posedge clk);
      wait_pin(s, 1'b0);
      chk("idle_oe", {15'h0, s ? cc_pin_b_oe[0] : cc_pin_a_oe[0]}, 16'h0000);
      rreg(4'h0);
      chk("cmp_flag", {15'h0, v[8 + s]}, 16'h0001);
      rreg(4'hA);
      chk("clr", {15'h0, v <= 16'h0040}, 16'h0001);
    end
    wreg(4'hE, 16'h0003);
    rreg(4'hE);
    chk("mode", v, 16'h0003);
    wreg(4'hE, 16'h0000);
    wreg(4'hD, 16'h0005);
    rreg(4'hD);
    chk("sync_sel", v, 16'h0005);
    wreg(4'hD, 16'h0000);
    $display("test compare done");
    for (int c = 0; c < 4; c++) begin
      wreg(4'h0, 16'(c));
      wreg(4'hA, 16'h0000);
      repeat (64) @(posedge clk);
      rreg(4'hA);
      chk("psc", {15'h0, v >= 16'(64 >> c) && v <= 16'((68 >> c) + 2)}, 16'h0001);
    end
    for (int k = 0; k < 4; k++) begin
      wreg(4'h0, 16'(k * 8 + 4 + k));
      wreg(4'hA, 16'h0000);
      pins.ext_pulses(k, 4);
      repeat (4) @(posedge clk);
      rreg(4'hA);
      chk("ext", v, k > 1 ? 16'h0008 : 16'h0004);
    end
    $display("test clock done");
    for (int s = 0; s < 2; s++) begin
      for (int e = 4; e < 7; e++) begin
        wreg(4'h1, 16'(e) << (4 * s));
        wreg(4'hB + s[3:0], 16'hFFFF);
        wreg(4'h0, 16'h0000);
        pins.drive(s, 1'b1);
        rreg(4'h0);
        chk("cap_rise", {15'h0, v[8 + s]}, {15'h0, e != 5});
        wreg(4'h0, 16'h0000);
        pins.drive(s, 1'b0);
        rreg(4'h0);
        chk("cap_fall", {15'h0, v[8 + s]}, {15'h0, e != 4});
      end
      rreg(4'hB + s[3:0]);
      chk("cap_val", {15'h0, v != 16'hFFFF}, 16'h0001);
    end
    $display("test capture done");
    end_sim();
  end
endmodule
